// ==== design/vmsad_slave.sv ====
// Overview of operation
// - a16 cycles answered for modifier 29h and 2Dh when enabled
// - a24 answered for 39h anywhere; 3Ah, 3Dh, 3Eh only in the main rack
// - a32 modifiers 09h, 0Ah, 0Dh, 0Eh answered only in the main rack
// - modifiers 10h through 1Fh are never selected or acknowledged
// - window base is a configuration input, so it avoids other modules
// - d8 and d16 transfers are served in any rack
// - d32 transfers are served only in the main rack
// - in an expansion rack only a16 and a24 decode
// - each transfer is a strobe and acknowledge handshake, no bus clock
// - grant and interrupt acknowledge chains are passed on to the next slot
`include "vmsad_regs.svh"
`timescale 1ns/1ns
`default_nettype none

module vmsad_slave #(
  parameter int WIN_BITS = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // backplane inputs
  input wire vmsad_pkg::vmsad_cyc_s busCyc,
  input wire vmsad_pkg::vmsad_ctl_s busCtl,
  input wire logic [31:0] busDataIn,
  // backplane outputs
  output logic [31:0] busDataOut,
  output logic busDataOe,
  output logic dtackOutN,
  output logic dtackOe,
  output logic iackOutN,
  output logic [3:0] bgOutN,
  // configuration
  input wire logic mainRack,
  input wire logic [9:0] amEnable,
  input wire logic [31:0] baseAddr,
  // local side
  output vmsad_pkg::vmsad_loc_s loc,
  output logic locReq,
  input wire logic locAck,
  input wire logic [31:0] locRdata
);

  localparam int CYC_W = $bits(vmsad_pkg::vmsad_cyc_s);
  localparam int CTL_W = $bits(vmsad_pkg::vmsad_ctl_s);
  localparam int SYN_W = CYC_W + CTL_W + 32;

  function automatic logic [9:0] amHot(input logic [5:0] am);
    amHot = {am == `VMSAD_AM_A32_SUP, am == `VMSAD_AM_A32_SUD,
             am == `VMSAD_AM_A32_NPP, am == `VMSAD_AM_A32_NPD,
             am == `VMSAD_AM_A24_SUP, am == `VMSAD_AM_A24_SUD,
             am == `VMSAD_AM_A24_NPP, am == `VMSAD_AM_A24_NPD,
             am == `VMSAD_AM_A16_SUP, am == `VMSAD_AM_A16_NPD};
  endfunction : amHot

  function automatic vmsad_pkg::vmsad_aw_e amWidth(input logic [9:0] hot);
    if (|(hot & `VMSAD_HOT_A16)) begin
      amWidth = vmsad_pkg::AW_A16;
    end else if (|(hot & `VMSAD_HOT_A24)) begin
      amWidth = vmsad_pkg::AW_A24;
    end else if (|(hot & `VMSAD_HOT_A32)) begin
      amWidth = vmsad_pkg::AW_A32;
    end else begin
      amWidth = vmsad_pkg::AW_NONE;
    end
  endfunction : amWidth

  function automatic logic winHit(input logic [31:0] a, input vmsad_pkg::vmsad_aw_e aw,
                                  input logic [31:0] base);
    logic [5:0] span;
    logic [32:0] top;
    logic [31:0] mask;
    span = (aw == vmsad_pkg::AW_A16) ? `VMSAD_SPAN_A16 :
           (aw == vmsad_pkg::AW_A24) ? `VMSAD_SPAN_A24 : `VMSAD_SPAN_A32;
    top = (33'h1 << span) - 33'h1;
    mask = top[31:0] & ~((32'h1 << WIN_BITS) - 32'h1);
    winHit = (aw != vmsad_pkg::AW_NONE) && ((a & mask) == (base & mask));
  endfunction : winHit

  function automatic vmsad_pkg::vmsad_dw_e dataWidth(input logic lwordN,
                                                     input logic [1:0] dsN);
    if (dsN == 2'h0) begin
      dataWidth = lwordN ? vmsad_pkg::DW_D16 : vmsad_pkg::DW_D32;
    end else if ((dsN != 2'h3) && lwordN) begin
      dataWidth = vmsad_pkg::DW_D8;
    end else begin
      dataWidth = vmsad_pkg::DW_BAD;
    end
  endfunction : dataWidth

  function automatic logic amReserved(input logic [5:0] am);
    amReserved = (am >= `VMSAD_RSV_LO) && (am <= `VMSAD_RSV_HI);
  endfunction : amReserved

  // synchronised pins
  logic [SYN_W-1:0] syncBus;
  vmsad_pkg::vmsad_cyc_s cycS;
  vmsad_pkg::vmsad_ctl_s ctlS;
  logic [31:0] dataS;

  vmsad_sync #(.W(SYN_W)) u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .din({busCyc, busCtl, busDataIn}),
    .dout(syncBus)
  );

  assign {cycS, ctlS, dataS} = syncBus;

  // state
  vmsad_pkg::vmsad_state_e state_r, state_nxt;
  vmsad_pkg::vmsad_cyc_s cycR_r;
  logic [1:0] dsPrev_r;
  logic [31:0] rdata_r;
  logic iackOutN_r;
  logic [3:0] bgOutN_r;

  // decode
  wire [9:0] hot = amHot(cycR_r.am);
  wire vmsad_pkg::vmsad_aw_e aw = amWidth(hot);
  wire [9:0] rackMask = mainRack ? `VMSAD_HOT_ALL : ~`VMSAD_MAIN_ONLY;
  wire rsv = amReserved(cycR_r.am);
  wire amOk = (|(hot & amEnable & rackMask)) && !rsv;
  wire vmsad_pkg::vmsad_dw_e dw = dataWidth(cycR_r.lwordN, ctlS.dsN);
  wire dwOk = (dw == vmsad_pkg::DW_D8) || (dw == vmsad_pkg::DW_D16) ||
              ((dw == vmsad_pkg::DW_D32) && mainRack);
  wire [31:0] addrFull = {cycR_r.addr, 1'h0};
  wire inWin = winHit(addrFull, aw, baseAddr);
  wire hit = amOk && inWin && dwOk;
  wire asLow = !ctlS.asN;
  wire dsSteady = (ctlS.dsN != 2'h3) && (ctlS.dsN == dsPrev_r);
  wire dsOff = (ctlS.dsN == 2'h3);

  // handshake sequencing
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      vmsad_pkg::ST_IDLE: begin
        if (asLow) begin
          state_nxt = vmsad_pkg::ST_ADDR;
        end
      end
      vmsad_pkg::ST_ADDR: begin
        if (!asLow) begin
          state_nxt = vmsad_pkg::ST_IDLE;
        end else if (dsSteady && hit) begin
          state_nxt = vmsad_pkg::ST_ACCESS;
        end
      end
      vmsad_pkg::ST_ACCESS: begin
        if (locAck) begin
          state_nxt = vmsad_pkg::ST_ACK;
        end
      end
      vmsad_pkg::ST_ACK: begin
        if (dsOff) begin
          state_nxt = vmsad_pkg::ST_IDLE;
        end
      end
      default: state_nxt = vmsad_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= vmsad_pkg::ST_IDLE;
      dsPrev_r <= 2'h3;
    end else begin
      state_r <= state_nxt;
      dsPrev_r <= ctlS.dsN;
    end
  end

  // address latch on strobe
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cycR_r <= '1;
    end else if (state_r == vmsad_pkg::ST_IDLE && asLow) begin
      cycR_r <= cycS;
    end
  end

  // local request contents
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      loc <= '0;
    end else if (state_r == vmsad_pkg::ST_ADDR && state_nxt == vmsad_pkg::ST_ACCESS) begin
      loc <= '{write: !cycR_r.writeN, width: dw, dsN: ctlS.dsN, am: cycR_r.am,
               addr: addrFull, wdata: dataS};
    end
  end

  // read data for the bus
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 32'h0;
    end else if (state_r == vmsad_pkg::ST_ACCESS && locAck) begin
      rdata_r <= locRdata;
    end
  end

  // daisy chains passed through
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      iackOutN_r <= 1'h1;
      bgOutN_r <= 4'hF;
    end else begin
      iackOutN_r <= ctlS.iackInN;
      bgOutN_r <= ctlS.bgInN;
    end
  end

  assign locReq = (state_r == vmsad_pkg::ST_ACCESS);
  assign dtackOe = (state_r == vmsad_pkg::ST_ACK);
  assign dtackOutN = 1'h0;
  assign busDataOe = (state_r == vmsad_pkg::ST_ACK) && cycR_r.writeN;
  assign busDataOut = rdata_r;
  assign iackOutN = iackOutN_r;
  assign bgOutN = bgOutN_r;

  // checks
  property p_a16Codes;
    @(posedge mclk) disable iff (!rst_n)
    $rose(locReq) && (loc.am[5:4] == 2'h2) |->
      (loc.am == `VMSAD_AM_A16_NPD) || (loc.am == `VMSAD_AM_A16_SUP);
  endproperty
  a_a16Codes: assert property (p_a16Codes) else $error("bad a16 modifier taken");

  property p_a24Expansion;
    @(posedge mclk) disable iff (!rst_n)
    $rose(locReq) && (loc.am[5:4] == 2'h3) && !mainRack |-> loc.am == `VMSAD_AM_A24_NPD;
  endproperty
  a_a24Expansion: assert property (p_a24Expansion) else $error("main only a24 taken");

  property p_a32Main;
    @(posedge mclk) disable iff (!rst_n)
    $rose(locReq) && (loc.am[5:4] == 2'h0) |-> $past(mainRack);
  endproperty
  a_a32Main: assert property (p_a32Main) else $error("a32 taken outside main rack");

  property p_noReserved;
    @(posedge mclk) disable iff (!rst_n)
    (dtackOe || locReq) |-> !amReserved(cycR_r.am);
  endproperty
  a_noReserved: assert property (p_noReserved) else $error("reserved modifier answered");

  property p_window;
    @(posedge mclk) disable iff (!rst_n)
    $rose(locReq) |-> $past(inWin) && loc.addr == addrFull;
  endproperty
  a_window: assert property (p_window) else $error("access outside window");

  property p_d16Width;
    @(posedge mclk) disable iff (!rst_n)
    $rose(locReq) && (loc.dsN == 2'h0) && cycR_r.lwordN |-> loc.width == vmsad_pkg::DW_D16;
  endproperty
  a_d16Width: assert property (p_d16Width) else $error("d16 misclassified");

  property p_d32Main;
    @(posedge mclk) disable iff (!rst_n)
    $rose(locReq) && (loc.width == vmsad_pkg::DW_D32) |-> $past(mainRack);
  endproperty
  a_d32Main: assert property (p_d32Main) else $error("d32 outside main rack");

  property p_expansionNoA32;
    @(posedge mclk) disable iff (!rst_n)
    !mainRack && $past(!mainRack) && (state_r == vmsad_pkg::ST_ADDR) &&
      (aw == vmsad_pkg::AW_A32) |=> state_r != vmsad_pkg::ST_ACCESS;
  endproperty
  a_expansionNoA32: assert property (p_expansionNoA32) else $error("a32 in expansion");

  property p_handshake;
    @(posedge mclk) disable iff (!rst_n)
    locReq && locAck |=> dtackOe && !locReq;
  endproperty
  a_handshake: assert property (p_handshake) else $error("acknowledge not held");

  property p_chainPass;
    @(posedge mclk) disable iff (!rst_n)
    ##1 1'b1 |-> iackOutN == $past(ctlS.iackInN) && bgOutN == $past(ctlS.bgInN);
  endproperty
  a_chainPass: assert property (p_chainPass) else $error("daisy chain not passed");

  property p_ackQualified;
    @(posedge mclk) disable iff (!rst_n)
    $rose(locReq) |-> $past(amOk) && $past(hit);
  endproperty
  a_ackQualified: assert property (p_ackQualified) else $error("unqualified access");

  property p_covRead;
    @(posedge mclk) disable iff (!rst_n)
    dtackOe && busDataOe;
  endproperty
  c_covRead: cover property (p_covRead);

  property p_covWrite;
    @(posedge mclk) disable iff (!rst_n)
    $rose(locReq) && loc.write;
  endproperty
  c_covWrite: cover property (p_covWrite);

  property p_covD32;
    @(posedge mclk) disable iff (!rst_n)
    $rose(locReq) && (loc.width == vmsad_pkg::DW_D32);
  endproperty
  c_covD32: cover property (p_covD32);

  property p_covMiss;
    @(posedge mclk) disable iff (!rst_n)
    (state_r == vmsad_pkg::ST_ADDR) && asLow && dsSteady && !hit;
  endproperty
  c_covMiss: cover property (p_covMiss);

endmodule : vmsad_slave

`default_nettype wire

// ==== design/vmsad_regs.svh ====
`ifndef VMSAD_REGS_SVH
`define VMSAD_REGS_SVH

// address modifier codes accepted by the decoder
`define VMSAD_AM_A16_NPD 6'h29
`define VMSAD_AM_A16_SUP 6'h2D
`define VMSAD_AM_A24_NPD 6'h39
`define VMSAD_AM_A24_NPP 6'h3A
`define VMSAD_AM_A24_SUD 6'h3D
`define VMSAD_AM_A24_SUP 6'h3E
`define VMSAD_AM_A32_NPD 6'h09
`define VMSAD_AM_A32_NPP 6'h0A
`define VMSAD_AM_A32_SUD 6'h0D
`define VMSAD_AM_A32_SUP 6'h0E

// reserved modifier range, never answered
`define VMSAD_RSV_LO 6'h10
`define VMSAD_RSV_HI 6'h1F

// one-hot code groups, bit order as the enable mask
`define VMSAD_HOT_A16 10'h003
`define VMSAD_HOT_A24 10'h03C
`define VMSAD_HOT_A32 10'h3C0
`define VMSAD_MAIN_ONLY 10'h3F8
`define VMSAD_HOT_ALL 10'h3FF

// address spans in bits
`define VMSAD_SPAN_A16 6'h10
`define VMSAD_SPAN_A24 6'h18
`define VMSAD_SPAN_A32 6'h20

`endif

// ==== design/vmsad_pkg.sv ====
package vmsad_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_ADDR = 2'h1,
    ST_ACCESS = 2'h3,
    ST_ACK = 2'h2
  } vmsad_state_e;

  typedef enum logic [1:0] {AW_A16, AW_A24, AW_A32, AW_NONE} vmsad_aw_e;

  typedef enum logic [1:0] {DW_D8, DW_D16, DW_D32, DW_BAD} vmsad_dw_e;

  // address phase as seen on the backplane
  typedef struct packed {
    logic writeN;
    logic lwordN;
    logic [5:0] am;
    logic [31:1] addr;
  } vmsad_cyc_s;

  // strobes and daisy chain inputs
  typedef struct packed {
    logic asN;
    logic [1:0] dsN;
    logic iackInN;
    logic [3:0] bgInN;
  } vmsad_ctl_s;

  // access handed to the local side
  typedef struct packed {
    logic write;
    vmsad_dw_e width;
    logic [1:0] dsN;
    logic [5:0] am;
    logic [31:0] addr;
    logic [31:0] wdata;
  } vmsad_loc_s;

endpackage : vmsad_pkg

// ==== design/vmsad_sync.sv ====
`timescale 1ns/1ns
`default_nettype none

module vmsad_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // data
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] meta_r;

  // two flops; first stage feeds only the second
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '1;
      dout <= '1;
    end else begin
      meta_r <= din;
      dout <= meta_r;
    end
  end

endmodule : vmsad_sync

`default_nettype wire

// ==== verification/vmsad_host_model.sv ====
`timescale 1ns/1ns
`default_nettype none

module vmsad_host_model (
  // clock
  input wire logic mclk,
  // slave answer
  input wire logic dtackOe,
  input wire logic [31:0] busDataOut,
  // master drive
  output var vmsad_pkg::vmsad_cyc_s busCyc,
  output var logic asN,
  output var logic [1:0] dsN,
  output var logic [31:0] busDataIn
);
  initial begin
    busCyc = '0;
    asN = 1'b1;
    dsN = 2'h3;
    busDataIn = 32'h0;
  end

  // address, then strobes, then wait for the acknowledge
  task automatic xfer(input logic [5:0] am, input logic [31:0] a, input logic wr,
    input logic lw, input logic [1:0] ds, input logic [31:0] wd,
    output logic hit, output logic [31:0] rd);
    int n;
    @(negedge mclk);
    busCyc = {!wr, lw, am, a[31:1]};
    busDataIn = wr ? wd : ~busDataIn;
    @(negedge mclk);
    asN = 1'b0;
    repeat (2) @(negedge mclk);
    dsN = ds;
    hit = 1'b0;
    for (n = 0; n < 30 && !hit; n++) begin
      @(negedge mclk);
      hit = (dtackOe === 1'b1);
    end
    rd = busDataOut;
    dsN = 2'h3;
    for (n = 0; n < 10 && dtackOe !== 1'b0; n++) begin
      @(negedge mclk);
    end
    asN = 1'b1;
    busDataIn = ~busDataIn;
    repeat (4) @(negedge mclk);
  endtask : xfer
endmodule : vmsad_host_model

`default_nettype wire

// ==== verification/test_vme_slave_address_decoder.sv ====
`timescale 1ns/1ns
`default_nettype none

module test_vme_slave_address_decoder;
  localparam logic [5:0] CODES [10] = '{6'h29, 6'h2D, 6'h39, 6'h3A, 6'h3D, 6'h3E,
    6'h09, 6'h0A, 6'h0D, 6'h0E};
  localparam logic [31:0] BASE = 32'h1234_5600;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  vmsad_pkg::vmsad_cyc_s busCyc;
  vmsad_pkg::vmsad_ctl_s busCtl;
  logic asN;
  logic [1:0] dsN;
  logic iackInN = 1'b1;
  logic [3:0] bgInN = 4'hF;
  logic [31:0] busDataIn;
  logic [31:0] busDataOut;
  logic busDataOe;
  logic dtackOutN;
  logic dtackOe;
  logic iackOutN;
  logic [3:0] bgOutN;
  logic mainRack = 1'b1;
  logic [9:0] amEnable = 10'h3FF;
  logic [31:0] baseAddr = BASE;
  vmsad_pkg::vmsad_loc_s loc;
  vmsad_pkg::vmsad_loc_s lastLoc;
  logic locReq;
  logic locAck = 1'b0;
  logic [31:0] locRdata = 32'h0;
  int ackDelay = 0;
  int lat = 0;
  int error_cnt = 0;
  int checks = 0;
  logic hit;
  logic [31:0] rd;
  logic oeSeen = 1'b0;

  // data drive level seen while the acknowledge stands
  always @(negedge mclk) begin
    if (dtackOe === 1'b1) begin
      oeSeen = busDataOe;
    end
  end

  assign busCtl = {asN, dsN, iackInN, bgInN};

  always #20 mclk = ~mclk;

  vmsad_host_model host (.mclk(mclk), .dtackOe(dtackOe), .busDataOut(busDataOut),
    .busCyc(busCyc), .asN(asN), .dsN(dsN), .busDataIn(busDataIn));

  vmsad_slave #(.WIN_BITS(8)) uut (.mclk(mclk), .rst_n(rst_n), .busCyc(busCyc),
    .busCtl(busCtl), .busDataIn(busDataIn), .busDataOut(busDataOut),
    .busDataOe(busDataOe), .dtackOutN(dtackOutN), .dtackOe(dtackOe),
    .iackOutN(iackOutN), .bgOutN(bgOutN), .mainRack(mainRack), .amEnable(amEnable),
    .baseAddr(baseAddr), .loc(loc), .locReq(locReq), .locAck(locAck),
    .locRdata(locRdata));

  // local side answers after a variable delay
  always @(negedge mclk) begin
    if (locReq === 1'b1 && !locAck) begin
      if (lat >= ackDelay) begin
        locAck = 1'b1;
        locRdata = 32'h5AC3_0000 | loc.am;
        lastLoc = loc;
        lat = 0;
      end else begin
        lat++;
      end
    end else begin
      locAck = 1'b0;
    end
  end

  task automatic cmp1(input string what, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask : cmp1

  task automatic cmp32(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp32

  task automatic stop_test();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test

  // every accepted modifier in both racks, reads with varying latency
  task automatic t_codes(input logic rack);
    logic exp;
    mainRack = rack;
    for (int i = 0; i < 10; i++) begin
      ackDelay = i % 3;
      exp = rack || i < 3;
      oeSeen = 1'b0;
      host.xfer(CODES[i], BASE + 32'h10, 1'b0, 1'b1, 2'h0, 32'h0, hit, rd);
      cmp1("code hit", exp, hit);
      cmp1("read drive", exp, oeSeen);
      cmp1("drive released", 1'b0, busDataOe);
      if (exp) cmp32("read data", 32'h5AC3_0000 | CODES[i], rd);
      cmp1("dtack released", 1'b0, dtackOe);
      cmp1("dtack level", 1'b0, dtackOutN);
    end
  endtask : t_codes

  // reserved modifiers inside the window
  task automatic t_reserved();
    mainRack = 1'b1;
    for (int am = 16; am < 32; am++) begin
      host.xfer(am[5:0], BASE, 1'b0, 1'b1, 2'h0, 32'h0, hit, rd);
      cmp1("reserved hit", 1'b0, hit);
    end
  endtask : t_reserved

  // window placement and per-code enables
  task automatic t_window();
    host.xfer(6'h39, BASE + 32'h100, 1'b0, 1'b1, 2'h0, 32'h0, hit, rd);
    cmp1("outside hit", 1'b0, hit);
    baseAddr = 32'h0000_7700;
    host.xfer(6'h29, 32'h0000_77FE, 1'b0, 1'b1, 2'h0, 32'h0, hit, rd);
    cmp1("moved base hit", 1'b1, hit);
    amEnable = 10'h3FE;
    host.xfer(6'h29, 32'h0000_77FE, 1'b0, 1'b1, 2'h0, 32'h0, hit, rd);
    cmp1("disabled hit", 1'b0, hit);
    amEnable = 10'h3FF;
    baseAddr = BASE;
  endtask : t_window

  // d8 and d16 writes in the expansion rack, d32 writes in both racks
  task automatic t_width();
    logic [1:0] dsT [5] = '{2'h2, 2'h1, 2'h0, 2'h0, 2'h0};
    logic lwT [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
    logic rackT [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
    logic [1:0] wT [5] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h2};
    logic exp;
    for (int i = 0; i < 5; i++) begin
      mainRack = rackT[i];
      exp = rackT[i] || wT[i] != 2'h2;
      oeSeen = 1'b1;
      host.xfer(6'h39, BASE + 32'h20, 1'b1, lwT[i], dsT[i], 32'hC0DE_0000 + i, hit, rd);
      cmp1("width hit", exp, hit);
      if (exp) begin
        cmp1("write drive", 1'b0, oeSeen);
        cmp32("write addr", BASE + 32'h20, lastLoc.addr);
        cmp32("width code", {30'h0, wT[i]}, {30'h0, lastLoc.width});
        cmp32("write data", 32'hC0DE_0000 + i, lastLoc.wdata);
        cmp1("write flag", 1'b1, lastLoc.write);
      end
    end
    mainRack = 1'b1;
  endtask : t_width

  // grant and acknowledge chains pass through
  task automatic t_chain();
    iackInN = 1'b0;
    bgInN = 4'h5;
    repeat (5) @(negedge mclk);
    cmp32("chain out", 32'h05, {27'h0, iackOutN, bgOutN});
    iackInN = 1'b1;
    bgInN = 4'hA;
    repeat (5) @(negedge mclk);
    cmp32("chain out", 32'h1A, {27'h0, iackOutN, bgOutN});
    bgInN = 4'hF;
  endtask : t_chain

  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    stop_test();
  end

  initial begin
    repeat (4) @(negedge mclk);
    cmp1("reset dtack", 1'b0, dtackOe);
    cmp1("reset req", 1'b0, locReq);
    rst_n = 1'b1;
    repeat (3) @(negedge mclk);
    t_codes(1'b1);
    t_codes(1'b0);
    t_reserved();
    t_window();
    t_width();
    t_chain();
    stop_test();
  end
endmodule : test_vme_slave_address_decoder

`default_nettype wire
